// File: shared/dpclk_regs.svh
`ifndef DPCLK_REGS_SVH
`define DPCLK_REGS_SVH
// ==========================================================
// register offsets
`define DPCLK_OFS_MIN_TU 12'h1c4
`define DPCLK_OFS_LINKCFG 12'h200
`define DPCLK_OFS_REFSEL 12'h204
`define DPCLK_OFS_RSTCTL 12'h208
`define DPCLK_OFS_STATUS 12'h20c
// ==========================================================
// field positions
`define DPCLK_CFG_RATE 1:0
`define DPCLK_CFG_W32 4
`define DPCLK_RST_VID 0
`define DPCLK_RST_AUD 1
`define DPCLK_RST_STRM_N 2
`define DPCLK_STAT_TMO 5
// ==========================================================
// reset values
`define DPCLK_RV_RATE 2'h1
`define DPCLK_RV_W32 1'h0
`define DPCLK_RV_REFSEL 1'h1
`define DPCLK_RV_RSTCTL 3'h3
`define DPCLK_RV_MIN_TU 32'h00000000
`define DPCLK_RV_FREQ 13'h0546
// ==========================================================
// line rates: code and rate in Mb/s
`define DPCLK_RATE_RBR 2'h0
`define DPCLK_RATE_HBR 2'h1
`define DPCLK_RATE_HBR2 2'h2
`define DPCLK_RATE_RSVD 2'h3
`define DPCLK_MBPS_RBR 13'h0654
`define DPCLK_MBPS_HBR 13'h0a8c
`define DPCLK_MBPS_HBR2 13'h1518
`define DPCLK_DIV16 6'h14
`define DPCLK_DIV32 6'h28
`define DPCLK_MASK16 32'h0000ffff
`define DPCLK_MASK32 32'hffffffff
`define DPCLK_MIN_TU_32 32'h00000004
`define DPCLK_DRP_RATE_ADDR 8'h88
// ==========================================================
// timing
`define DPCLK_CLK_NS 50
`define DPCLK_AUX_NS 1000
`define DPCLK_AUX_CYC ((`DPCLK_AUX_NS) / (`DPCLK_CLK_NS))
`define DPCLK_LOCK_TMO_NS 1000000
// ==========================================================
// synchroniser bit map
`define DPCLK_NSYNC 4
`define DPCLK_IN_LOCK 0
`define DPCLK_IN_DONE 1
`define DPCLK_IN_RDY 2
`define DPCLK_IN_CABLE 3
`endif

// File: shared/dpclk_pkg.sv
package dpclk_pkg;
  typedef enum logic [1:0] {
    ST_WRITE,
    ST_WAIT_RDY,
    ST_WAIT_LOCK,
    ST_RUN
  } dpclk_state_type;
endpackage

// File: shared/dpclk_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpclk_regs.svh"
interface dpclk_sync_if;
  logic [`DPCLK_NSYNC-1:0] raw;
  logic [`DPCLK_NSYNC-1:0] sync;
  modport stage (input raw, output sync);
  modport user (output raw, input sync);
endinterface
`default_nettype wire

// File: verilog/dpclk_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpclk_regs.svh"
module dpclk_sync
  import dpclk_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  dpclk_sync_if.stage sb // raw pins in, synchronised levels out
);
  logic [`DPCLK_NSYNC-1:0] meta;
  logic [`DPCLK_NSYNC-1:0] hold;

  // ==========================================================
  // two flops per pin; meta feeds hold and nothing else
  for (genvar i = 0; i < `DPCLK_NSYNC; i++)
  begin : g_bit
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        meta[i] <= 1'h0;
        hold[i] <= 1'h0;
      end
      else if (ce)
      begin
        meta[i] <= sb.raw[i];
        hold[i] <= meta[i];
      end
    end
  end

  assign sb.sync = hold;
endmodule // dpclk_sync
`default_nettype wire

// File: verilog/dpclk_ctrl.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "dpclk_regs.svh"
module dpclk_ctrl
  import dpclk_pkg::*;
#(
  parameter int LOCK_TMO_CYC = `DPCLK_LOCK_TMO_NS / `DPCLK_CLK_NS
)
(
  input wire logic mclk, // 20 MHz host clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [11:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic pll_lock_pin, // transceiver pll lock, async
  input wire logic reset_done_pin, // transceiver reset done, async
  input wire logic drp_rdy_pin, // reconfiguration port ready, async
  input wire logic cable_pin, // cable present, async
  input wire logic [23:0] mvid_in, // video M value from link
  input wire logic [23:0] nvid_in, // video N value from link
  input wire logic mn_valid, // M and N valid pulse
  output logic refclk_sel, // 1 selects refclk_input_one
  output logic drp_en, // reconfiguration access strobe
  output logic drp_we, // reconfiguration write enable
  output logic [7:0] drp_addr, // reconfiguration address
  output logic [15:0] drp_wdata, // reconfiguration write data
  output logic lnk_rst, // link-domain reset, active high
  output logic [5:0] clkgen_div, // clock generator divide ratio
  output logic [12:0] lnk_freq, // link clock in 100 kHz units
  output logic gt_width32, // 32-bit transceiver width applied
  output logic [31:0] gt_lane_mask, // valid bits of transceiver buses
  output logic aux_tick, // aux timing strobe
  output logic [23:0] vid_m, // latched video M
  output logic [23:0] vid_n, // latched video N
  output logic vid_rst, // video reset, active high
  output logic aud_rst, // audio interface reset, active high
  output logic aud_strm_rst_n // audio stream reset, active low
);
  // ==========================================================
  // declarations
  localparam logic [19:0] TMO_LAST = 20'(LOCK_TMO_CYC - 1);
  localparam logic [4:0] AUX_LAST = 5'(`DPCLK_AUX_CYC - 1);

  dpclk_sync_if sif ();
  dpclk_state_type state;
  dpclk_state_type next_state;
  logic lock_s;
  logic done_s;
  logic rdy_s;
  logic cable_s;
  logic rdy_q;
  logic rdy_rise;
  logic [1:0] cfg_rate;
  logic cfg_w32;
  logic [1:0] act_rate;
  logic [31:0] min_tu;
  logic tmo_flag;
  logic [19:0] tmr;
  logic tmr_hit;
  logic tmo_set;
  logic [4:0] aux_cnt;
  logic [12:0] rate_mbps;
  logic wr_cfg;
  logic wr_ref;
  logic wr_tu;
  logic wr_rst;
  logic wr_stat;
  logic apply;
  logic tu_small;
  logic [31:0] stat_word;
  logic [31:0] rd_val;

  // ==========================================================
  // pin synchronisers
  assign sif.raw = {cable_pin, drp_rdy_pin, reset_done_pin, pll_lock_pin};

  dpclk_sync i_dpclk_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .sb(sif)
  );

  assign lock_s = sif.sync[`DPCLK_IN_LOCK];
  assign done_s = sif.sync[`DPCLK_IN_DONE];
  assign rdy_s = sif.sync[`DPCLK_IN_RDY];
  assign cable_s = sif.sync[`DPCLK_IN_CABLE];
  assign rdy_rise = rdy_s && !rdy_q;

  // ==========================================================
  // decode
  assign wr_cfg = wr && (addr == `DPCLK_OFS_LINKCFG);
  assign wr_ref = wr && (addr == `DPCLK_OFS_REFSEL);
  assign wr_tu = wr && (addr == `DPCLK_OFS_MIN_TU);
  assign wr_rst = wr && (addr == `DPCLK_OFS_RSTCTL);
  assign wr_stat = wr && (addr == `DPCLK_OFS_STATUS);
  assign apply = (state == ST_WRITE);
  assign tmr_hit = (tmr >= TMO_LAST);
  assign tmo_set = tmr_hit && (state inside {ST_WAIT_RDY, ST_WAIT_LOCK});
  assign rate_mbps = (cfg_rate == `DPCLK_RATE_RBR) ? `DPCLK_MBPS_RBR :
                     (cfg_rate == `DPCLK_RATE_HBR2) ? `DPCLK_MBPS_HBR2 :
                     `DPCLK_MBPS_HBR;
  // software must keep this at 4 or more in 32-bit mode; we only flag it
  assign tu_small = gt_width32 && (min_tu < `DPCLK_MIN_TU_32);
  assign stat_word = {26'h0, tmo_flag, tu_small, !lnk_rst, cable_s,
                      done_s, lock_s};
  assign rd_val =
    (addr == `DPCLK_OFS_MIN_TU) ? min_tu :
    (addr == `DPCLK_OFS_LINKCFG) ? {27'h0, cfg_w32, 2'h0, cfg_rate} :
    (addr == `DPCLK_OFS_REFSEL) ? {31'h0, refclk_sel} :
    (addr == `DPCLK_OFS_RSTCTL) ? {29'h0, aud_strm_rst_n, aud_rst, vid_rst} :
    (addr == `DPCLK_OFS_STATUS) ? stat_word : 32'h0;

  // ==========================================================
  // software registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_rate <= `DPCLK_RV_RATE;
      cfg_w32 <= `DPCLK_RV_W32;
    end
    else if (ce && wr_cfg)
    begin
      // reserved rate code leaves the rate alone
      if (wdata[`DPCLK_CFG_RATE] != `DPCLK_RATE_RSVD)
        cfg_rate <= wdata[`DPCLK_CFG_RATE];
      cfg_w32 <= wdata[`DPCLK_CFG_W32];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      refclk_sel <= `DPCLK_RV_REFSEL;
    else if (ce && wr_ref)
      refclk_sel <= wdata[0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      min_tu <= `DPCLK_RV_MIN_TU;
    else if (ce && wr_tu)
      min_tu <= wdata;
  end

  // resets leave as flop levels; each domain resynchronises its own
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      {aud_strm_rst_n, aud_rst, vid_rst} <= `DPCLK_RV_RSTCTL;
    else if (ce && wr_rst)
    begin
      vid_rst <= wdata[`DPCLK_RST_VID];
      aud_rst <= wdata[`DPCLK_RST_AUD];
      aud_strm_rst_n <= wdata[`DPCLK_RST_STRM_N];
    end
  end

  // set beats a write-one-to-clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tmo_flag <= 1'h0;
    else if (ce && tmo_set)
      tmo_flag <= 1'h1;
    else if (ce && wr_stat && wdata[`DPCLK_STAT_TMO])
      tmo_flag <= 1'h0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata <= 32'h0;
    else if (ce)
      rdata <= rd ? rd_val : 32'h0;
  end

  // ==========================================================
  // reconfiguration sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      ST_WRITE: next_state = ST_WAIT_RDY;
      ST_WAIT_RDY:
        if (rdy_rise)
          next_state = ST_WAIT_LOCK;
        else if (tmr_hit)
          next_state = ST_WRITE;
      ST_WAIT_LOCK:
        if (lock_s && done_s && cable_s)
          next_state = ST_RUN;
        else if (tmr_hit)
          next_state = ST_WRITE;
      ST_RUN:
        // recovered clock is unusable without cable or lock
        if (!lock_s || !cable_s)
          next_state = ST_WAIT_LOCK;
      default: next_state = ST_WRITE;
    endcase
    if (wr_cfg)
      next_state = ST_WRITE;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= ST_WRITE;
      lnk_rst <= 1'h1;
      rdy_q <= 1'h0;
    end
    else if (ce)
    begin
      state <= next_state;
      lnk_rst <= (next_state != ST_RUN);
      rdy_q <= rdy_s;
    end
  end

  // one shared timer bounds both waits; a stuck pll retries the write
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tmr <= 20'h0;
    else if (ce && (state != next_state))
      tmr <= 20'h0;
    else if (ce && !tmr_hit)
      tmr <= tmr + 20'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      drp_en <= 1'h0;
      drp_we <= 1'h0;
      drp_addr <= 8'h0;
      drp_wdata <= 16'h0;
    end
    else if (ce)
    begin
      drp_en <= apply;
      drp_we <= apply;
      drp_addr <= `DPCLK_DRP_RATE_ADDR;
      drp_wdata <= {11'h0, cfg_w32, 2'h0, cfg_rate};
    end
  end

  // ==========================================================
  // applied clock settings, only changed by a reconfiguration
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      act_rate <= `DPCLK_RV_RATE;
      gt_width32 <= `DPCLK_RV_W32;
      clkgen_div <= `DPCLK_DIV16;
      lnk_freq <= `DPCLK_RV_FREQ;
      gt_lane_mask <= `DPCLK_MASK16;
    end
    else if (ce && apply)
    begin
      act_rate <= cfg_rate;
      gt_width32 <= cfg_w32;
      clkgen_div <= cfg_w32 ? `DPCLK_DIV32 : `DPCLK_DIV16;
      // in 100 kHz units rate/20 is a half and rate/40 a quarter
      lnk_freq <= cfg_w32 ? (rate_mbps >> 2) : (rate_mbps >> 1);
      gt_lane_mask <= cfg_w32 ? `DPCLK_MASK32 : `DPCLK_MASK16;
    end
  end

  // ==========================================================
  // aux strobe and video regeneration values
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      aux_cnt <= 5'h0;
      aux_tick <= 1'h0;
    end
    else if (ce)
    begin
      aux_cnt <= (aux_cnt == AUX_LAST) ? 5'h0 : aux_cnt + 5'h1;
      aux_tick <= (aux_cnt == AUX_LAST);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      vid_m <= 24'h0;
      vid_n <= 24'h0;
    end
    else if (ce && mn_valid && (state == ST_RUN))
    begin
      vid_m <= mvid_in;
      vid_n <= nvid_in;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n || !ce);

  a_reset_state: assert property (disable iff (1'b0)
    !rst_n |=> refclk_sel && lnk_rst && (state == ST_WRITE))
    else $error("reset state wrong");
  a_div_width: assert property (
    apply |=> clkgen_div == ($past(cfg_w32) ? `DPCLK_DIV32 : `DPCLK_DIV16))
    else $error("divider does not follow width");
  a_hbr_freq: assert property (
    apply && (cfg_rate == `DPCLK_RATE_HBR) && !cfg_w32
    |=> lnk_freq == `DPCLK_RV_FREQ)
    else $error("link frequency wrong at middle rate");
  a_drp_write: assert property (
    apply |=> drp_en && drp_we && (drp_addr == `DPCLK_DRP_RATE_ADDR))
    else $error("rate write not issued");
  a_refsel_write: assert property (
    wr_ref |=> refclk_sel == $past(wdata[0]))
    else $error("reference select not written");
  a_cable_loss: assert property (
    (state == ST_RUN) && !cable_s |=> lnk_rst)
    else $error("link not reset on cable loss");
  a_aux_gap: assert property (
    aux_tick |=> !aux_tick [*8])
    else $error("aux strobe too frequent");
  a_vid_latch: assert property (
    mn_valid && (state == ST_RUN) |=> vid_m == $past(mvid_in))
    else $error("video M not latched");
  a_lane_mask: assert property (
    gt_lane_mask == (gt_width32 ? `DPCLK_MASK32 : `DPCLK_MASK16))
    else $error("lane mask disagrees with width");
  a_run_lock: assert property (
    $fell(lnk_rst) |-> $past(lock_s) && $past(done_s))
    else $error("link released without lock");
  a_tmo_sticky: assert property (
    tmo_set |=> tmo_flag)
    else $error("timeout flag lost");

  c_run: cover property (!lnk_rst);
  c_timeout: cover property (tmo_set);
  c_w32_run: cover property (gt_width32 && !lnk_rst);
  c_refsel_zero: cover property (!refclk_sel && !lnk_rst);
endmodule // dpclk_ctrl
`default_nettype wire

// File: sim/dpclk_gt_model.sv
`timescale 1ns/10ps
`default_nettype none
module dpclk_gt_model
(
  input wire logic mclk, // bench time base
  input wire logic [7:0] dly, // answer delay in cycles
  input wire logic drp_en, // reconfiguration strobe from the core
  input wire logic cable_on, // bench plugs or pulls the cable
  output logic drp_rdy_pin, // ready, pulsed per write
  output logic pll_lock_pin, // pll lock level
  output logic reset_done_pin, // transceiver reset done level
  output logic cable_pin // cable present level
);
  int cnt;
  initial
  begin
    cnt = 0;
    drp_rdy_pin = 1'b0;
    pll_lock_pin = 1'b0;
    reset_done_pin = 1'b0;
  end
  assign cable_pin = cable_on;
  // =========================================
  // reprogramming drops lock until ready and a settle time have passed
  always @(posedge mclk)
  begin
    if (drp_en === 1'b1)
    begin
      cnt <= 1;
      drp_rdy_pin <= 1'b0;
      pll_lock_pin <= 1'b0;
      reset_done_pin <= 1'b0;
    end
    else if (cnt != 0)
    begin
      cnt <= cnt + 1;
      drp_rdy_pin <= (cnt >= dly) && (cnt < dly + 3);
      if (cnt >= 2 * dly)
      begin
        // lock stands for a good 270 MHz reference on the chosen input
        pll_lock_pin <= 1'b1;
        reset_done_pin <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule // dpclk_gt_model
`default_nettype wire

// File: sim/tb_dp_core_clock_reset_scheme.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpclk_regs.svh"
module tb_dp_core_clock_reset_scheme;
  import dpclk_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic mn_valid = 1'b0;
  logic cable_on = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rv, gt_lane_mask;
  logic [23:0] mvid_in = 24'h0;
  logic [23:0] nvid_in = 24'h0;
  logic [23:0] vid_m, vid_n;
  logic [7:0] dly = 8'h03;
  logic [7:0] drp_addr;
  logic [15:0] drp_wdata;
  logic [5:0] clkgen_div;
  logic [12:0] lnk_freq;
  logic drp_rdy_pin, pll_lock_pin, reset_done_pin, cable_pin, refclk_sel;
  logic drp_en, drp_we, lnk_rst, gt_width32, aux_tick;
  logic vid_rst, aud_rst, aud_strm_rst_n;
  int error_cnt = 0;
  int n_tests = 0;
  int t, w, r;
  logic [12:0] mbps [3] = '{`DPCLK_MBPS_RBR, `DPCLK_MBPS_HBR, `DPCLK_MBPS_HBR2};

  // 20 MHz host clock, never faster than any link clock
  always #25 mclk = ~mclk;

  dpclk_ctrl #(.LOCK_TMO_CYC(50)) i_dpclk_ctrl (.mclk(mclk), .rst_n(rst_n),
    .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pll_lock_pin(pll_lock_pin), .reset_done_pin(reset_done_pin),
    .drp_rdy_pin(drp_rdy_pin), .cable_pin(cable_pin), .mvid_in(mvid_in),
    .nvid_in(nvid_in), .mn_valid(mn_valid), .refclk_sel(refclk_sel),
    .drp_en(drp_en), .drp_we(drp_we), .drp_addr(drp_addr),
    .drp_wdata(drp_wdata), .lnk_rst(lnk_rst), .clkgen_div(clkgen_div),
    .lnk_freq(lnk_freq), .gt_width32(gt_width32),
    .gt_lane_mask(gt_lane_mask), .aux_tick(aux_tick), .vid_m(vid_m),
    .vid_n(vid_n), .vid_rst(vid_rst), .aud_rst(aud_rst),
    .aud_strm_rst_n(aud_strm_rst_n));

  dpclk_gt_model i_dpclk_gt_model (.mclk(mclk), .dly(dly), .drp_en(drp_en),
    .cable_on(cable_on), .drp_rdy_pin(drp_rdy_pin),
    .pll_lock_pin(pll_lock_pin), .reset_done_pin(reset_done_pin),
    .cable_pin(cable_pin));

  // =========================================
  // bus and check tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask
  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd_reg(a, rv);
    chk(nm, e, rv);
  endtask
  task wait_drp;
    for (t = 0; t < 10 && drp_en !== 1'b1; t++) @(negedge mclk);
    chk("drp_en", 32'h1, {31'h0, drp_en});
  endtask
  task wait_run;
    for (t = 0; t < 300 && lnk_rst !== 1'b0; t++) @(negedge mclk);
    chk("lnk_rst run", 32'h0, {31'h0, lnk_rst});
  endtask
  task results;
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // =========================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("refclk_sel", 32'h1, {31'h0, refclk_sel});
    chk("rst levels", 32'h3, {29'h0, aud_strm_rst_n, aud_rst, vid_rst});
    chk("lnk_freq rst", 32'h546, {19'h0, lnk_freq});
    wait_drp();
    wait_run();
    rd_chk("refsel", `DPCLK_OFS_REFSEL, 32'h1);
    rd_chk("rstctl", `DPCLK_OFS_RSTCTL, 32'h3);
    rd_chk("min_tu", `DPCLK_OFS_MIN_TU, 32'h0);
    rd_chk("linkcfg", `DPCLK_OFS_LINKCFG, 32'h1);
    rd_chk("unmapped", 12'h000, 32'h0);
    @(negedge mclk);
    chk("rdata idle", 32'h0, rdata);
    for (w = 0; w < 2; w++)
      for (r = 0; r < 3; r++)
      begin
        dly <= (w != 0) ? 8'h14 : 8'h03;
        wr_reg(`DPCLK_OFS_LINKCFG, 32'(w * 16 + r));
        wait_drp();
        chk("lnk_rst held", 32'h1, {31'h0, lnk_rst});
        chk("drp_we", 32'h1, {31'h0, drp_we});
        chk("drp_addr", 32'(`DPCLK_DRP_RATE_ADDR), 32'(drp_addr));
        chk("drp_wdata", 32'(w * 16 + r), 32'(drp_wdata));
        chk("clkgen_div", (w != 0) ? 32'h28 : 32'h14, 32'(clkgen_div));
        chk("lnk_freq", 32'(mbps[r]) * 10 / ((w != 0) ? 40 : 20),
          32'(lnk_freq));
        chk("lane_mask", (w != 0) ? `DPCLK_MASK32 : `DPCLK_MASK16,
          gt_lane_mask);
        chk("width32", 32'(w), {31'h0, gt_width32});
        wait_run();
      end
    // reserved rate code keeps the rate but still restarts
    wr_reg(`DPCLK_OFS_LINKCFG, 32'h13);
    wait_drp();
    chk("rate kept", 32'h2, 32'(drp_wdata[1:0]));
    wait_run();
    rd_chk("linkcfg", `DPCLK_OFS_LINKCFG, 32'h12);
    rd_reg(`DPCLK_OFS_STATUS, rv);
    chk("min_tu low", 32'h1f, {27'h0, rv[4:0]});
    wr_reg(`DPCLK_OFS_MIN_TU, `DPCLK_MIN_TU_32);
    rd_reg(`DPCLK_OFS_STATUS, rv);
    chk("min_tu ok", 32'h0f, {27'h0, rv[4:0]});
    rd_chk("min_tu", `DPCLK_OFS_MIN_TU, 32'h4);
    wr_reg(`DPCLK_OFS_REFSEL, 32'h0);
    @(negedge mclk);
    chk("refclk_sel", 32'h0, {31'h0, refclk_sel});
    wr_reg(`DPCLK_OFS_RSTCTL, 32'h4);
    @(negedge mclk);
    chk("rst levels", 32'h4, {29'h0, aud_strm_rst_n, aud_rst, vid_rst});
    @(posedge mclk);
    mvid_in <= 24'h123456;
    nvid_in <= 24'h00abcd;
    mn_valid <= 1'b1;
    @(posedge mclk);
    mn_valid <= 1'b0;
    @(negedge mclk);
    chk("vid_m", 32'h123456, 32'(vid_m));
    chk("vid_n", 32'h00abcd, 32'(vid_n));
    for (t = 0; t < 40 && aux_tick !== 1'b1; t++) @(negedge mclk);
    @(negedge mclk);
    for (t = 1; t < 40 && aux_tick !== 1'b1; t++) @(negedge mclk);
    chk("aux period", 32'(`DPCLK_AUX_CYC), 32'(t));
    @(posedge mclk);
    cable_on <= 1'b0;
    repeat (4) @(negedge mclk);
    chk("lnk_rst unplug", 32'h1, {31'h0, lnk_rst});
    repeat (80) @(negedge mclk);
    rd_reg(`DPCLK_OFS_STATUS, rv);
    chk("timeout flag", 32'h1, {31'h0, rv[5]});
    @(posedge mclk);
    cable_on <= 1'b1;
    wait_run();
    // write one clears the sticky timeout once the link runs again
    wr_reg(`DPCLK_OFS_STATUS, 32'h20);
    rd_reg(`DPCLK_OFS_STATUS, rv);
    chk("timeout clear", 32'h0, {31'h0, rv[5]});
    results();
  end

  initial
  begin
    #(50 * 20000);
    error_cnt++;
    results();
  end
endmodule // tb_dp_core_clock_reset_scheme
`default_nettype wire
